//--- core/cca_core.sv
// clear channel assessment core with register port
//
// Chosen here: strobed register access.
`timescale 1ns/100ps
`default_nettype none
module cca_core #(
  parameter int RESULT_CYC = cca_pkg::CCA_RESULT_CYC,
  parameter int ED_CYC = cca_pkg::CCA_ED_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // receiver status inputs
  input wire logic rx_listen,
  input wire logic rx_frame,
  input wire logic shr_detect,
  input wire logic [7:0] ed_level,
  input wire logic carrier_sense,
  input wire logic [4:0] trx_state,
  // outputs
  output logic measure_done_irq,
  output logic preamble_detect_disable,
  output logic busy_level
);
  import cca_pkg::*;

  typedef struct packed {
    cca_state_t st;
    logic [1:0] mode;         // channel_check_mode_sel
    logic [4:0] chan;         // low control bits, stored only
    logic [7:0] thres;        // energy_threshold register
    logic [7:0] sync;         // receive_sync_control register
    logic done;               // channel_check_done
    logic idle;               // channel_idle_flag
    logic busy_acc;           // busy seen during listen window
    logic [31:0] cnt;         // listen window counter
    logic ed_run;             // automated measurement active
    logic [31:0] ed_cnt;      // automated measurement counter
    logic ed_armed;           // one measurement per frame
    logic irq;                // interrupt pulse
    logic busy;               // check in progress, feeds busy_level
    logic [7:0] rdata;        // read data register
  } cca_q_t;

  cca_q_t s_q, s_d;

  // energy test: ed level in dB above floor vs twice threshold
  function automatic logic cca_energy_busy(input logic [7:0] ed,
                                           input logic [4:0] thr);
    cca_energy_busy = ed > {2'h0, thr, 1'b0}; // [RL7] [RL23]
  endfunction

  // mode combine of both tests
  function automatic logic cca_busy(input logic [1:0] m, input logic e,
                                    input logic c);
    case (m)
      CHANNEL_CHECK_MODE_SEL_ED: cca_busy = e;       // [RL1]
      CHANNEL_CHECK_MODE_SEL_CS: cca_busy = c;       // [RL2] [RL11]
      CHANNEL_CHECK_MODE_SEL_AND: cca_busy = e & c;  // [RL3]
      default: cca_busy = e | c;       // [RL3]
    endcase
  endfunction

  logic e_busy;
  logic now_busy;
  logic req;
  logic [1:0] req_mode;  // mode written beside the request bit
  logic req_busy;        // busy verdict under the newly written mode
  assign e_busy = cca_energy_busy(ed_level, s_q.thres[CCA_THR_HI:0]);
  // an immediate answer must use the mode written with the request,
  // not the one still held from the previous write
  assign req_mode = reg_wdata[CHANNEL_CHECK_MODE_SEL_HI:CHANNEL_CHECK_MODE_SEL_LO];
  assign req_busy = cca_busy(req_mode, e_busy, carrier_sense);
  assign now_busy = cca_busy(s_q.mode, e_busy, carrier_sense);
  assign req = reg_wr && reg_addr == CCA_ADDR_CTRL
               && reg_wdata[CCA_BIT_REQ];                  // [RL4]

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.irq = 1'b0;
    s_d.rdata = 8'h00;
    // automated measurement after each header, once per frame
    if (shr_detect && !s_q.ed_armed) begin
      s_d.ed_run = 1'b1;                                   // [RL16]
      s_d.ed_cnt = 32'h0;
      s_d.ed_armed = 1'b1;
    end else if (s_q.ed_run) begin
      if (s_q.ed_cnt == 32'(ED_CYC - 1)) begin
        s_d.ed_run = 1'b0;
      end else begin
        s_d.ed_cnt = s_q.ed_cnt + 32'h1;
      end
    end
    if (!rx_frame && !shr_detect) begin
      s_d.ed_armed = 1'b0;  // re-arm once the frame is over
    end
    // register writes; request bit is never stored
    if (reg_wr) begin
      case (reg_addr)
        CCA_ADDR_CTRL: begin
          s_d.mode = reg_wdata[CHANNEL_CHECK_MODE_SEL_HI:CHANNEL_CHECK_MODE_SEL_LO];   // [RL21] [RL20]
          s_d.chan = reg_wdata[4:0];
        end
        CCA_ADDR_THRES: s_d.thres = reg_wdata;             // [RL22]
        CCA_ADDR_SYNC: s_d.sync = reg_wdata;               // [RL17]
        default: ;
      endcase
    end
    // sequencer
    case (s_q.st)
      CCA_IDLE: begin
        if (req) begin
          s_d.done = 1'b0;                                 // [RL9]
          s_d.idle = 1'b0;
          if (rx_listen && !rx_frame) begin
            s_d.st = CCA_LISTEN;                           // [RL5] [RL17]
            s_d.cnt = 32'h0;
            s_d.busy_acc = 1'b0;
          end else if (rx_frame) begin
            if (req_mode == CHANNEL_CHECK_MODE_SEL_CS || !s_q.ed_run) begin
              s_d.done = 1'b1;                             // [RL14] [RL15]
              s_d.idle = !req_busy;
              s_d.irq = 1'b1;
            end else begin
              s_d.st = CCA_WAIT_ED;                        // [RL14] [RL13]
            end
          end else begin
            s_d.done = 1'b1;                               // [RL12]
            s_d.irq = 1'b1;
          end
        end
      end
      CCA_LISTEN: begin
        s_d.busy_acc = s_q.busy_acc | now_busy;
        if (s_q.cnt == 32'(RESULT_CYC - 1)) begin
          s_d.st = CCA_IDLE;
          s_d.done = 1'b1;                                 // [RL10]
          s_d.idle = !(s_q.busy_acc | now_busy);
          s_d.irq = 1'b1;                                  // [RL6]
        end else begin
          s_d.cnt = s_q.cnt + 32'h1;
        end
      end
      CCA_WAIT_ED: begin
        // finishes with the automated measurement, busy taken at its end
        if (!s_q.ed_run) begin
          s_d.st = CCA_IDLE;
          s_d.done = 1'b1;                                 // [RL10] [RL14]
          s_d.idle = !now_busy;
          s_d.irq = 1'b1;                                  // [RL6]
        end
      end
      default: s_d.st = CCA_IDLE;
    endcase
    // busy flag registered so the output comes straight from a flop
    s_d.busy = s_d.st != CCA_IDLE;
    // register reads, data in the next cycle
    if (reg_rd) begin
      case (reg_addr)
        CCA_ADDR_STATUS: s_d.rdata = {s_q.done, s_q.idle, 1'b0,
                                      trx_state};           // [RL8]
        CCA_ADDR_CTRL: s_d.rdata = {1'b0, s_q.mode, s_q.chan};
        CCA_ADDR_THRES: s_d.rdata = s_q.thres;
        CCA_ADDR_SYNC: s_d.rdata = s_q.sync;
        default: s_d.rdata = 8'h00;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.st <= CCA_IDLE;
      s_q.mode <= CCA_CTRL_RST[6:5];
      s_q.chan <= CCA_CTRL_RST[4:0];
      s_q.thres <= ENERGY_THRESHOLD_RST;
      s_q.sync <= CCA_SYNC_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign reg_rdata = s_q.rdata;
  assign measure_done_irq = s_q.irq;
  assign preamble_detect_disable = s_q.sync[CCA_PDT_BIT];  // [RL17]
  assign busy_level = s_q.busy;
endmodule
`default_nettype wire

//--- core/cca_pkg.sv
// package of constants and types for the channel check block
// Functional notes
// RL1: mode 1 busy when energy above threshold
// RL2: mode 2 busy only on carrier sense
// RL3: mode 0 ORs, mode 3 ANDs both tests
// RL4: host requests via control register in receive
// RL5: listen state result after 140 us
// RL6: pulse done interrupt when manual check ends
// RL7: energy busy above floor plus twice threshold
// RL8: done and idle readable in status register
// RL9: new request clears done and idle
// RL10: end sets done; idle only if not busy
// RL11: carrier sense flags compliant signal above floor
// RL12: request outside receive: done, irq, no measure
// RL13: frame-state request may give extra early irq
// RL14: frame state energy modes wait for measurement
// RL15: frame state mode 2 answers at once
// RL16: one automated energy measurement per header
// RL17: preamble detect disable keeps listen state
// RL18: host avoids requests in extended mode
// RL19: host requests only in listen state
// RL20: request bit self-clears, reads zero
// RL21: mode selector at control bits 6 to 5
// RL22: threshold field at bits 4 to 0
// RL23: floor level is base of threshold
package cca_pkg;
  localparam logic [7:0] CCA_ADDR_STATUS = 8'h01;
  localparam logic [7:0] CCA_ADDR_CTRL = 8'h08;
  localparam logic [7:0] CCA_ADDR_THRES = 8'h09;
  localparam logic [7:0] CCA_ADDR_SYNC = 8'h15;
  localparam int CCA_BIT_DONE = 7;
  localparam int CCA_BIT_IDLE = 6;
  localparam int CCA_BIT_REQ = 7;
  localparam int CHANNEL_CHECK_MODE_SEL_HI = 6;
  localparam int CHANNEL_CHECK_MODE_SEL_LO = 5;
  localparam int CCA_THR_HI = 4;
  localparam int CCA_PDT_BIT = 7;
  localparam logic [6:0] CCA_CTRL_RST = 7'h2B;
  localparam logic [7:0] ENERGY_THRESHOLD_RST = 8'hC7;
  localparam logic [7:0] CCA_SYNC_RST = 8'h00;
  localparam logic [7:0] CCA_ED_FLOOR_DBM = 8'hA5;
  localparam int CCA_CLK_MHZ = 200;
  localparam int CCA_RESULT_US = 140;
  localparam int CCA_ED_US = 128;
  localparam int CCA_RESULT_CYC = CCA_RESULT_US * CCA_CLK_MHZ;
  localparam int CCA_ED_CYC = CCA_ED_US * CCA_CLK_MHZ;
  localparam logic [1:0] CHANNEL_CHECK_MODE_SEL_OR = 2'h0;
  localparam logic [1:0] CHANNEL_CHECK_MODE_SEL_ED = 2'h1;
  localparam logic [1:0] CHANNEL_CHECK_MODE_SEL_CS = 2'h2;
  localparam logic [1:0] CHANNEL_CHECK_MODE_SEL_AND = 2'h3;
  typedef enum logic [3:0] {
    CCA_IDLE = 4'h1,
    CCA_LISTEN = 4'h2,
    CCA_WAIT_ED = 4'h4,
    CCA_SPARE = 4'h8
  } cca_state_t;
endpackage

//--- test/cca_core_assertions.sv
// checker for the channel check core ports
`timescale 1ns/100ps
`default_nettype none
module cca_chk #(
  parameter int RESULT_CYC = 20,
  parameter int ED_CYC = 16
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // receiver and result
  input wire logic rx_listen,
  input wire logic rx_frame,
  input wire logic measure_done_irq,
  input wire logic busy_level
);
  import cca_pkg::*;
  // one cycle of slack: the answer edge may count from either side
  localparam int R1 = RESULT_CYC + 1;
  logic req; // request accepted by an idle sequencer
  logic lreq; // request in the listen state
  assign req = reg_wr && reg_addr == CCA_ADDR_CTRL && reg_wdata[7] && !busy_level;
  assign lreq = req && rx_listen && !rx_frame;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_irq_one_pulse: assert property (measure_done_irq |=> !measure_done_irq)
    else $error("done pulse longer than one cycle");
  a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside read slot");
  a_req_reads_zero: assert property (reg_rd && reg_addr == CCA_ADDR_CTRL |=> !reg_rdata[7])
    else $error("request bit reads one");
  a_listen_busy: assert property (lreq |=> busy_level)
    else $error("listen request not started");
  a_listen_quiet: assert property (lreq |=> !measure_done_irq [*8])
    else $error("listen check ends early");
  a_listen_time: assert property (lreq |-> ##[RESULT_CYC:R1] measure_done_irq)
    else $error("listen check late");
  a_outside_done: assert property (req && !rx_listen && !rx_frame |=> measure_done_irq)
    else $error("request outside receive gave no pulse");
  a_frame_carrier: assert property (req && rx_frame && reg_wdata[6:5] == CHANNEL_CHECK_MODE_SEL_CS |=> measure_done_irq)
    else $error("carrier mode in frame not at once");
  a_busy_ends: assert property ($fell(busy_level) |-> measure_done_irq)
    else $error("check ended with no pulse");
endmodule
bind cca_core cca_chk #(.RESULT_CYC(RESULT_CYC), .ED_CYC(ED_CYC)) u_chk (.clk_sys, .rst,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .rx_listen, .rx_frame,
  .measure_done_irq, .busy_level);
`default_nettype wire

//--- test/test_clear_channel_assessment.sv
// register level bench for the channel check core
`timescale 1ns/100ps
`default_nettype none
module test_clear_channel_assessment;
  import cca_pkg::*;
  localparam int RC = 20; // shortened listen window
  localparam int EC = 16; // shortened energy window
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, ed_level = 8'h00;
  logic rx_listen = 1'b1, rx_frame = 1'b0, shr_detect = 1'b0, carrier_sense = 1'b0;
  logic [4:0] trx_state = 5'h06; // arbitrary state code shown in status
  logic measure_done_irq, preamble_detect_disable, busy_level, bsy;
  int bad_count = 0, checked = 0, c;
  always #2.5 clk_sys = ~clk_sys;
  cca_core #(.RESULT_CYC(RC), .ED_CYC(EC)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_listen(rx_listen), .rx_frame(rx_frame),
    .shr_detect(shr_detect), .ed_level(ed_level), .carrier_sense(carrier_sense),
    .trx_state(trx_state), .measure_done_irq(measure_done_irq),
    .preamble_detect_disable(preamble_detect_disable), .busy_level(busy_level));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one write cycle; the strobe drops right after its sampling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // read data is taken in the one cycle where it stands
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk("rdata", reg_rdata, e);
    @(posedge clk_sys);
  endtask
  // bounded wait for the done pulse; c gives the cycles waited
  task automatic wirq(input int n);
    c = 0;
    #1;
    while (measure_done_irq !== 1'b1 && c < n) begin
      @(posedge clk_sys);
      #1 c++;
    end
    if (c >= n) begin
      bad_count++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rd(CCA_ADDR_CTRL, {1'b0, CCA_CTRL_RST});
    rd(CCA_ADDR_THRES, ENERGY_THRESHOLD_RST);
    rd(CCA_ADDR_STATUS, {3'h0, trx_state});
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h00);
    wr(CCA_ADDR_THRES, 8'h05); // energy busy above 10
    // every mode against carrier and energy just on either side of the line
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 4; k++) begin
        carrier_sense <= k[0];
        ed_level <= k[1] ? 8'h0B : 8'h0A;
        bsy = (m == 0) ? (k[0] | k[1]) : (m == 1) ? k[1] : (m == 2) ? k[0] : (k[0] & k[1]);
        @(posedge clk_sys);
        wr(CCA_ADDR_CTRL, {1'b1, m[1:0], 5'h0B});
        rd(CCA_ADDR_STATUS, {3'h0, trx_state});
        wirq(RC + 4);
        rd(CCA_ADDR_STATUS, {1'b1, !bsy, 1'b0, trx_state});
      end
    end
    rx_listen <= 1'b0; // outside receive: no measurement
    wr(CCA_ADDR_CTRL, 8'hAB);
    wirq(3);
    rd(CCA_ADDR_STATUS, {3'h4, trx_state});
    rx_frame <= 1'b1; // frame state, energy above the line
    shr_detect <= 1'b1;
    @(posedge clk_sys);
    shr_detect <= 1'b0;
    wr(CCA_ADDR_CTRL, 8'hAB);
    wirq(EC + 4);
    chk("wait", c > 2, 1'b1);
    rd(CCA_ADDR_STATUS, {3'h4, trx_state});
    shr_detect <= 1'b1; // no second measurement in one frame
    @(posedge clk_sys);
    shr_detect <= 1'b0;
    wr(CCA_ADDR_CTRL, 8'hAB); // basic mode only
    wirq(3);
    chk("late", c < 2, 1'b1);
    rx_frame <= 1'b0; // new frame re-arms the measurement
    @(posedge clk_sys);
    rx_frame <= 1'b1;
    shr_detect <= 1'b1;
    @(posedge clk_sys);
    shr_detect <= 1'b0;
    wr(CCA_ADDR_CTRL, 8'hCB); // frame state, carrier mode answers at once during the measurement
    wirq(3);
    chk("cs_now", c < 2, 1'b1);
    rd(CCA_ADDR_STATUS, {3'h4, trx_state});
    rx_frame <= 1'b0;
    rx_listen <= 1'b1;
    wr(CCA_ADDR_SYNC, 8'h80);
    rd(CCA_ADDR_SYNC, 8'h80);
    chk("pdd", preamble_detect_disable, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
